// >>> common/ppp_pkg.sv
package ppp_pkg;

  // Command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR  = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR  = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR    = 8'h11;
  localparam logic [7:0] CMD_SIG_RD   = 8'h08;
  localparam logic [7:0] CMD_FUSE_RD  = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD    = 8'h03;

  // Load target codes {sel1, sel0}
  localparam logic [1:0] LT_ADDR = 2'b00;
  localparam logic [1:0] LT_DATA = 2'b01;
  localparam logic [1:0] LT_CMD  = 2'b10;

  // Memory geometry
  localparam int FLASH_AW      = 15;
  localparam int FLASH_WORD_AW = 7;
  localparam int FLASH_PAGES_W = 8;
  localparam int EE_AW         = 11;
  localparam int EE_WORD_AW    = 3;
  localparam int FLASH_PAGE_WORDS = 1 << FLASH_WORD_AW;
  localparam int EE_PAGE_BYTES    = 1 << EE_WORD_AW;

  // Pin synchroniser layout
  localparam int PIN_W      = 16;
  localparam int PIN_LT1    = 15;
  localparam int PIN_LT0    = 14;
  localparam int PIN_BSA    = 13;
  localparam int PIN_BSB    = 12;
  localparam int PIN_ACT    = 11;
  localparam int PIN_PGL    = 10;
  localparam int PIN_WR_N   = 9;
  localparam int PIN_OE_N   = 8;
  localparam int PIN_DATA_H = 7;

  // Self-timed operation lengths, least values rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WRITE_US    = 3700;
  localparam int T_ERASE_US    = 7500;
  localparam int WRITE_CYC     = (T_WRITE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC     = (T_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 20;

  // Values after reset; 1 means unprogrammed
  localparam logic [7:0] FUSE_LOW_RST  = 8'hff;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST  = 8'hff;
  localparam logic [7:0] LOCK_RST      = 8'hff;
  localparam logic [7:0] DATA_RST      = 8'hff;
  localparam int         KEEP_EE_BIT   = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE_FLASH,
    ST_ERASE_EE,
    ST_ERASE_LOCK,
    ST_PROG_FLASH,
    ST_PROG_EE,
    ST_WAIT
  } ppp_state_t;

  // Identity bytes; values are arbitrary
  function automatic logic [7:0] ppp_sig_byte(input logic [1:0] idx);
    unique case (idx)
      2'h0:    ppp_sig_byte = 8'h5a;
      2'h1:    ppp_sig_byte = 8'h3c;
      2'h2:    ppp_sig_byte = 8'h01;
      default: ppp_sig_byte = 8'hff;
    endcase
  endfunction : ppp_sig_byte

  // Calibration bytes; values are arbitrary
  function automatic logic [7:0] ppp_cal_byte(input logic [1:0] idx);
    unique case (idx)
      2'h0: ppp_cal_byte = 8'h80;
      2'h1: ppp_cal_byte = 8'h81;
      2'h2: ppp_cal_byte = 8'h82;
      2'h3: ppp_cal_byte = 8'h83;
    endcase
  endfunction : ppp_cal_byte

endpackage : ppp_pkg

// >>> src/ppp_mem.sv
`timescale 1ns/1ps
`default_nettype none

module ppp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read; write-then-read returns old data
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : ppp_mem

`default_nettype wire

// >>> src/ppp_port.sv
// Summary of operation
// - Command and address stay loaded across operations until reloaded.
// - Erase command then write strobe low starts chip erase, busy low.
// - Chip erase clears flash, EEPROM and lock bits, never fuses.
// - Lock bits clear only after the whole flash erase has finished.
// - Keep-EEPROM fuse programmed makes chip erase skip the EEPROM.
// - Target 10, byte select A low, action strobe rise loads command.
// - Target 00 action strobe loads address low or high byte by select A.
// - Target 01 action strobe loads data low or high byte by select A.
// - Page latch rise with select A high copies data into page buffer.
// - Low address bits pick word in page, upper bits pick the page.
// - Flash write command, strobe low, select A low programs page, busy.
// - No-operation command ends page programming, clears write state.
// - EEPROM write command latches bytes, strobe low programs the page.
// - Flash read drives word low or high byte by select A.
// - EEPROM read with select A low drives the addressed byte.
// - Fuse write: data low byte, selects choose low, high, extended.
// - Lock write programs zero bits; only chip erase clears locks.
// - Fuse read: selects B/A 00 low, 11 high, 10 extended, 01 lock.
// - Signature read with select A low returns byte at address 0-2.
// - Signature command with select A high returns calibration 0-3.
// - Ready/busy is 0 during erase or write, 1 when ready.
// - Data bus driven only while output enable is low.
`timescale 1ns/1ps
`default_nettype none

module ppp_port
  import ppp_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       load_target_sel1,
  input  wire logic       load_target_sel0,
  input  wire logic       byte_sel_a,
  input  wire logic       byte_sel_b,
  input  wire logic       action_strobe,
  input  wire logic       page_latch_strobe,
  input  wire logic       wr_n,
  input  wire logic       oe_n,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output var  logic       data_oe,
  output var  logic       ready_busy_flag
);

  logic [PIN_W-1:0]      sync1_reg;
  logic [PIN_W-1:0]      sync2_reg;
  logic                  act_prev_reg;
  logic                  pgl_prev_reg;
  logic                  wr_n_prev_reg;
  logic [1:0]            s_lt;
  logic                  s_bsa;
  logic                  s_bsb;
  logic [7:0]            s_data;
  logic                  act_rise;
  logic                  pgl_rise;
  logic                  wr_fall;
  logic [7:0]            cmd_reg;
  logic [15:0]           addr_reg;
  logic [7:0]            data_lo_reg;
  logic [7:0]            data_hi_reg;
  logic [FLASH_PAGE_WORDS-1:0] fmask_reg;
  logic [EE_PAGE_BYTES-1:0]    emask_reg;
  ppp_state_t            state_reg;
  logic [FLASH_AW-1:0]   idx_reg;
  logic                  phase_reg;
  logic [TIMER_W-1:0]    timer_reg;
  logic [TIMER_W-1:0]    limit_reg;
  logic [FLASH_PAGES_W-1:0] page_reg;
  logic [7:0]            fuse_low_reg;
  logic [7:0]            fuse_high_reg;
  logic [7:0]            fuse_ext_reg;
  logic [7:0]            lock_reg;
  logic                  keep_eeprom_fuse;
  logic                  start_ok;
  logic                  walk_end;
  logic                  fbuf_wr;
  logic                  ebuf_wr;
  logic [15:0]           fbuf_rd;
  logic [7:0]            ebuf_rd;
  logic                  flash_wr;
  logic [FLASH_AW-1:0]   flash_wr_addr;
  logic [15:0]           flash_wr_data;
  logic [15:0]           flash_rd;
  logic                  ee_wr;
  logic [EE_AW-1:0]      ee_wr_addr;
  logic [7:0]            ee_wr_data;
  logic [7:0]            ee_rd;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= {load_target_sel1, load_target_sel0, byte_sel_a, byte_sel_b,
                    action_strobe, page_latch_strobe, wr_n, oe_n, data_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Edge history sits after the second stage only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // High like the reset sync stage, so no false rise
      act_prev_reg  <= 1'b1;
      pgl_prev_reg  <= 1'b1;
      wr_n_prev_reg <= 1'b1;
    end else begin
      act_prev_reg  <= sync2_reg[PIN_ACT];
      pgl_prev_reg  <= sync2_reg[PIN_PGL];
      wr_n_prev_reg <= sync2_reg[PIN_WR_N];
    end
  end

  assign s_lt     = sync2_reg[PIN_LT1:PIN_LT0];
  assign s_bsa    = sync2_reg[PIN_BSA];
  assign s_bsb    = sync2_reg[PIN_BSB];
  assign s_data   = sync2_reg[PIN_DATA_H:0];
  assign act_rise = sync2_reg[PIN_ACT] & ~act_prev_reg;
  assign pgl_rise = sync2_reg[PIN_PGL] & ~pgl_prev_reg;
  assign wr_fall  = wr_n_prev_reg & ~sync2_reg[PIN_WR_N];
  assign start_ok = wr_fall & (state_reg == ST_IDLE);
  // Fuse bit 0 means programmed
  assign keep_eeprom_fuse = ~fuse_high_reg[KEEP_EE_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_reg     <= CMD_NOP;
      addr_reg    <= '0;
      data_lo_reg <= DATA_RST;
      data_hi_reg <= DATA_RST;
    end else if (act_rise) begin
      unique case (s_lt)
        LT_CMD: begin
          if (!s_bsa) begin
            cmd_reg <= s_data;
          end
        end
        LT_ADDR: begin
          if (s_bsa) begin
            addr_reg[15:8] <= s_data;
          end else begin
            addr_reg[7:0] <= s_data;
          end
        end
        LT_DATA: begin
          if (s_bsa) begin
            data_hi_reg <= s_data;
          end else begin
            data_lo_reg <= s_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign fbuf_wr = pgl_rise & s_bsa & (cmd_reg == CMD_FLASH_WR);
  assign ebuf_wr = pgl_rise & s_bsa & (cmd_reg == CMD_EE_WR);

  // Loaded-word masks keep stale buffer words out of the array
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fmask_reg <= '0;
      emask_reg <= '0;
    end else begin
      if (act_rise && s_lt == LT_CMD && !s_bsa && s_data == CMD_NOP) begin
        fmask_reg <= '0;
        emask_reg <= '0;
      end
      if (state_reg == ST_PROG_FLASH && walk_end) begin
        fmask_reg <= '0;
      end
      if (state_reg == ST_PROG_EE && walk_end) begin
        emask_reg <= '0;
      end
      // Set after clear so a new latch wins
      if (fbuf_wr) begin
        fmask_reg[addr_reg[FLASH_WORD_AW-1:0]] <= 1'b1;
      end
      if (ebuf_wr) begin
        emask_reg[addr_reg[EE_WORD_AW-1:0]] <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (state_reg)
      ST_ERASE_FLASH: walk_end = &idx_reg;
      ST_ERASE_EE:    walk_end = &idx_reg[EE_AW-1:0];
      ST_PROG_FLASH:  walk_end = phase_reg & (&idx_reg[FLASH_WORD_AW-1:0]);
      ST_PROG_EE:     walk_end = phase_reg & (&idx_reg[EE_WORD_AW-1:0]);
      default:        walk_end = 1'b0;
    endcase
  end

  // Operation sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg       <= ST_IDLE;
      idx_reg         <= '0;
      phase_reg       <= 1'b0;
      timer_reg       <= '0;
      limit_reg       <= '0;
      page_reg        <= '0;
      ready_busy_flag <= 1'b1;
    end else begin
      timer_reg <= timer_reg + 1'b1;
      unique case (state_reg)
        ST_IDLE: begin
          idx_reg   <= '0;
          phase_reg <= 1'b0;
          timer_reg <= '0;
          limit_reg <= TIMER_W'(WRITE_CYCLES - 1);
          if (start_ok) begin
            unique case (cmd_reg)
              CMD_ERASE: begin
                state_reg       <= ST_ERASE_FLASH;
                limit_reg       <= TIMER_W'(ERASE_CYCLES - 1);
                ready_busy_flag <= 1'b0;
              end
              CMD_FLASH_WR: begin
                if (!s_bsa) begin
                  state_reg       <= ST_PROG_FLASH;
                  page_reg        <= addr_reg[FLASH_AW-1:FLASH_WORD_AW];
                  ready_busy_flag <= 1'b0;
                end
              end
              CMD_EE_WR: begin
                if (!s_bsa) begin
                  state_reg       <= ST_PROG_EE;
                  page_reg        <= addr_reg[EE_AW-1:EE_WORD_AW];
                  ready_busy_flag <= 1'b0;
                end
              end
              CMD_FUSE_WR, CMD_LOCK_WR: begin
                state_reg       <= ST_WAIT;
                ready_busy_flag <= 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
        ST_ERASE_FLASH: begin
          idx_reg <= idx_reg + 1'b1;
          if (walk_end) begin
            state_reg <= keep_eeprom_fuse ? ST_ERASE_LOCK : ST_ERASE_EE;
          end
        end
        ST_ERASE_EE: begin
          idx_reg <= idx_reg + 1'b1;
          if (walk_end) begin
            state_reg <= ST_ERASE_LOCK;
          end
        end
        ST_ERASE_LOCK: begin
          state_reg <= ST_WAIT;
        end
        ST_PROG_FLASH, ST_PROG_EE: begin
          // Phase 0 reads buffer, phase 1 writes array
          phase_reg <= ~phase_reg;
          if (phase_reg) begin
            idx_reg <= idx_reg + 1'b1;
          end
          if (walk_end) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timer_reg >= limit_reg) begin
            state_reg       <= ST_IDLE;
            ready_busy_flag <= 1'b1;
          end
        end
      endcase
    end
  end

  // word from low bits, page from upper
  always_comb begin
    flash_wr      = 1'b0;
    flash_wr_addr = {page_reg, idx_reg[FLASH_WORD_AW-1:0]};
    flash_wr_data = fbuf_rd;
    ee_wr         = 1'b0;
    ee_wr_addr    = {page_reg, idx_reg[EE_WORD_AW-1:0]};
    ee_wr_data    = ebuf_rd;
    // erase writes blank flash and EEPROM
    if (state_reg == ST_ERASE_FLASH) begin
      flash_wr      = 1'b1;
      flash_wr_addr = idx_reg;
      flash_wr_data = '1;
    end
    if (state_reg == ST_ERASE_EE) begin
      ee_wr      = 1'b1;
      ee_wr_addr = idx_reg[EE_AW-1:0];
      ee_wr_data = '1;
    end
    if (state_reg == ST_PROG_FLASH && phase_reg) begin
      flash_wr = fmask_reg[idx_reg[FLASH_WORD_AW-1:0]];
    end
    if (state_reg == ST_PROG_EE && phase_reg) begin
      ee_wr = emask_reg[idx_reg[EE_WORD_AW-1:0]];
    end
  end

  // Fuse and lock storage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fuse_low_reg  <= FUSE_LOW_RST;
      fuse_high_reg <= FUSE_HIGH_RST;
      fuse_ext_reg  <= FUSE_EXT_RST;
      lock_reg      <= LOCK_RST;
    end else begin
      if (start_ok && cmd_reg == CMD_FUSE_WR) begin
        if (s_bsb) begin
          fuse_ext_reg <= data_lo_reg;
        end else if (s_bsa) begin
          fuse_high_reg <= data_lo_reg;
        end else begin
          fuse_low_reg <= data_lo_reg;
        end
      end
      if (start_ok && cmd_reg == CMD_LOCK_WR) begin
        lock_reg <= lock_reg & data_lo_reg;
      end
      if (state_reg == ST_ERASE_LOCK) begin
        lock_reg <= LOCK_RST;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= ~sync2_reg[PIN_OE_N];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out <= DATA_RST;
    end else begin
      unique case (cmd_reg)
        CMD_FLASH_RD: data_out <= s_bsa ? flash_rd[15:8] : flash_rd[7:0];
        CMD_EE_RD:    data_out <= s_bsa ? DATA_RST : ee_rd;
        CMD_FUSE_RD: begin
          unique case ({s_bsb, s_bsa})
            2'b00: data_out <= fuse_low_reg;
            2'b11: data_out <= fuse_high_reg;
            2'b10: data_out <= fuse_ext_reg;
            2'b01: data_out <= lock_reg;
          endcase
        end
        CMD_SIG_RD: data_out <= s_bsa ? ppp_cal_byte(addr_reg[1:0]) : ppp_sig_byte(addr_reg[1:0]);
        default:    data_out <= DATA_RST;
      endcase
    end
  end

  ppp_mem #(.WIDTH(16), .DEPTH(1 << FLASH_AW)) u_flash (
    .clk     (ref_clk),
    .wr_en   (flash_wr),
    .wr_addr (flash_wr_addr),
    .wr_data (flash_wr_data),
    .rd_addr (addr_reg[FLASH_AW-1:0]),
    .rd_data (flash_rd)
  );

  ppp_mem #(.WIDTH(8), .DEPTH(1 << EE_AW)) u_eeprom (
    .clk     (ref_clk),
    .wr_en   (ee_wr),
    .wr_addr (ee_wr_addr),
    .wr_data (ee_wr_data),
    .rd_addr (addr_reg[EE_AW-1:0]),
    .rd_data (ee_rd)
  );

  ppp_mem #(.WIDTH(16), .DEPTH(FLASH_PAGE_WORDS)) u_flash_buf (
    .clk     (ref_clk),
    .wr_en   (fbuf_wr),
    .wr_addr (addr_reg[FLASH_WORD_AW-1:0]),
    .wr_data ({data_hi_reg, data_lo_reg}),
    .rd_addr (idx_reg[FLASH_WORD_AW-1:0]),
    .rd_data (fbuf_rd)
  );

  ppp_mem #(.WIDTH(8), .DEPTH(EE_PAGE_BYTES)) u_ee_buf (
    .clk     (ref_clk),
    .wr_en   (ebuf_wr),
    .wr_addr (addr_reg[EE_WORD_AW-1:0]),
    .wr_data (data_lo_reg),
    .rd_addr (idx_reg[EE_WORD_AW-1:0]),
    .rd_data (ebuf_rd)
  );

endmodule : ppp_port

`default_nettype wire

// >>> tb/ppp_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module ppp_port_assertions
  import ppp_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       load_target_sel1,
  input wire logic       load_target_sel0,
  input wire logic       byte_sel_a,
  input wire logic       byte_sel_b,
  input wire logic       action_strobe,
  input wire logic       page_latch_strobe,
  input wire logic       wr_n,
  input wire logic       oe_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       ready_busy_flag
);
  localparam int MIN_BUSY  = (WRITE_CYCLES < ERASE_CYCLES) ? WRITE_CYCLES : ERASE_CYCLES;
  localparam int ERASE_MIN = 32768;
  logic [7:0] cmd_reg;
  logic       act_reg;
  logic       erase_reg;
  int         busy_cnt;
  logic       wr_go;
  logic       wr_skip;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Pin-level copy of the command; the device sees it a few edges later
  always_ff @(posedge ref_clk) begin
    act_reg <= action_strobe;
    if (rst) cmd_reg <= CMD_NOP;
    else if (action_strobe && !act_reg && load_target_sel1 && !load_target_sel0 && !byte_sel_a) cmd_reg <= data_in;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || ready_busy_flag) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) erase_reg <= 1'b0;
    else if ($fell(wr_n) && ready_busy_flag) erase_reg <= (cmd_reg == CMD_ERASE);
  end
  assign wr_go = cmd_reg inside {CMD_FUSE_WR, CMD_LOCK_WR} || (cmd_reg inside {CMD_FLASH_WR, CMD_EE_WR} && !byte_sel_a);
  assign wr_skip = cmd_reg inside {CMD_NOP, CMD_SIG_RD, CMD_FUSE_RD, CMD_FLASH_RD, CMD_EE_RD}
                   || (cmd_reg inside {CMD_FLASH_WR, CMD_EE_WR} && byte_sel_a);
  a_oe_follows_pin: assert property (data_oe == !$past(oe_n, 3))
    else $error("data_oe does not follow oe_n");
  a_bus_released: assert property ($rose(oe_n) && data_oe |-> data_oe [*3] ##1 !data_oe)
    else $error("bus not released after oe_n high");
  a_erase_goes_busy: assert property ($fell(wr_n) && ready_busy_flag && cmd_reg == CMD_ERASE |-> ##3 !ready_busy_flag)
    else $error("erase did not raise busy");
  a_write_goes_busy: assert property ($fell(wr_n) && ready_busy_flag && wr_go |-> ##2 ready_busy_flag ##1 !ready_busy_flag)
    else $error("write did not raise busy on time");
  a_refused_wr_quiet: assert property ($fell(wr_n) && ready_busy_flag && wr_skip |-> ready_busy_flag [*6])
    else $error("refused write strobe made busy");
  a_busy_has_cause: assert property ($fell(ready_busy_flag) |-> $past(wr_n, 4) && !$past(wr_n, 3))
    else $error("busy without write strobe");
  a_busy_min_len: assert property ($rose(ready_busy_flag) |-> busy_cnt >= MIN_BUSY)
    else $error("busy too short");
  a_erase_full_walk: assert property ($rose(ready_busy_flag) && erase_reg |-> busy_cnt >= ERASE_MIN)
    else $error("erase ended before flash walk");
  c_erase_done: cover property ($rose(ready_busy_flag) && erase_reg);
  c_bus_driven: cover property ($rose(data_oe));
  c_write_busy: cover property ($fell(ready_busy_flag) && !erase_reg);
endmodule : ppp_port_assertions

bind ppp_port ppp_port_assertions #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)
) u_chk (
  .ref_clk(ref_clk), .rst(rst), .load_target_sel1(load_target_sel1), .load_target_sel0(load_target_sel0),
  .byte_sel_a(byte_sel_a), .byte_sel_b(byte_sel_b), .action_strobe(action_strobe),
  .page_latch_strobe(page_latch_strobe), .wr_n(wr_n), .oe_n(oe_n), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag)
);

`default_nettype wire

// >>> tb/ppp_programmer.sv
`timescale 1ns/1ps
`default_nettype none

module ppp_programmer (
  input  wire logic       ref_clk,
  input  wire logic [7:0] dev_out,
  input  wire logic       dev_oe,
  input  wire logic       ready_busy_flag,
  output var  logic       load_target_sel1,
  output var  logic       load_target_sel0,
  output var  logic       byte_sel_a,
  output var  logic       byte_sel_b,
  output var  logic       action_strobe,
  output var  logic       page_latch_strobe,
  output var  logic       wr_n,
  output var  logic       oe_n,
  output wire logic [7:0] data_in
);
  logic [7:0] bus_val;
  // Floating bus shows no stale value
  assign data_in = dev_oe ? dev_out : (oe_n ? bus_val : ~bus_val);
  initial begin
    {load_target_sel1, load_target_sel0} = 2'b11;
    {byte_sel_a, byte_sel_b, action_strobe, page_latch_strobe} = 4'h0;
    {wr_n, oe_n} = 2'b11;
    bus_val = 8'hff;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  // target, select and data held around pulse
  task automatic load(input logic [1:0] lt, input logic a, input logic [7:0] v);
    {load_target_sel1, load_target_sel0} = lt;
    byte_sel_a = a;
    bus_val = v;
    idle(5);
    action_strobe = 1'b1;
    idle(5);
    action_strobe = 1'b0;
    idle(5);
  endtask : load
  task automatic latch();
    byte_sel_a = 1'b1;
    idle(5);
    page_latch_strobe = 1'b1;
    idle(5);
    page_latch_strobe = 1'b0;
    idle(5);
  endtask : latch
  task automatic write(input logic a, input logic b, input int lim, output logic busy, output logic done);
    int i;
    busy = 1'b0;
    done = 1'b0;
    byte_sel_a = a;
    byte_sel_b = b;
    idle(5);
    wr_n = 1'b0;
    for (i = 0; i < lim && !done; i++) begin
      idle(1);
      if (i == 4) wr_n = 1'b1;
      if (ready_busy_flag !== 1'b1) busy = 1'b1;
      else if (busy && i > 4) done = 1'b1;
    end
    idle(5);
  endtask : write
  task automatic read(input logic a, input logic b, output logic [7:0] v, output logic oe);
    byte_sel_a = a;
    byte_sel_b = b;
    oe_n = 1'b0;
    idle(8);
    v = data_in;
    oe = dev_oe;
    oe_n = 1'b1;
    idle(5);
  endtask : read
endmodule : ppp_programmer

`default_nettype wire

// >>> tb/tb_ppp_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ppp_port;
  import ppp_pkg::*;
  logic       ref_clk;
  logic       rst;
  logic       lt1, lt0, bsa, bsb, act, pgl, wr_n, oe_n, doe, rdy;
  logic [7:0] din;
  logic [7:0] dout;
  int         bad_count;
  int         total_checks;
  ppp_port #(.WRITE_CYCLES(2), .ERASE_CYCLES(2)) dut (
    .ref_clk(ref_clk), .rst(rst), .load_target_sel1(lt1), .load_target_sel0(lt0), .byte_sel_a(bsa),
    .byte_sel_b(bsb), .action_strobe(act), .page_latch_strobe(pgl), .wr_n(wr_n), .oe_n(oe_n),
    .data_in(din), .data_out(dout), .data_oe(doe), .ready_busy_flag(rdy)
  );
  ppp_programmer prog (
    .ref_clk(ref_clk), .dev_out(dout), .dev_oe(doe), .ready_busy_flag(rdy), .load_target_sel1(lt1),
    .load_target_sel0(lt0), .byte_sel_a(bsa), .byte_sel_b(bsb), .action_strobe(act),
    .page_latch_strobe(pgl), .wr_n(wr_n), .oe_n(oe_n), .data_in(din)
  );
  always #5 ref_clk = ~ref_clk;
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd(input logic a, input logic b, input logic [7:0] exp);
    logic [7:0] v;
    logic       oe;
    prog.read(a, b, v, oe);
    check("data_in", exp, v);
    check("data_oe", 8'h01, {7'h0, oe});
  endtask : rd
  task automatic wr(input logic a, input logic b, input int lim, input logic exp);
    logic busy;
    logic done;
    prog.write(a, b, lim, busy, done);
    check("busy seen", {7'h0, exp}, {7'h0, busy});
    // Bounded wait ran out
    if (exp && done !== 1'b1) begin
      check("ready_busy_flag", 8'h01, {7'h0, done});
      results();
    end
  endtask : wr
  task automatic t_fuses();
    prog.load(LT_CMD, 1'b0, CMD_FUSE_WR);
    prog.load(LT_DATA, 1'b0, 8'ha5);
    wr(1'b0, 1'b0, 60, 1'b1);
    prog.load(LT_DATA, 1'b0, 8'hf7);
    wr(1'b1, 1'b0, 60, 1'b1);
    prog.load(LT_DATA, 1'b0, 8'hfd);
    wr(1'b0, 1'b1, 60, 1'b1);
    prog.load(LT_CMD, 1'b0, CMD_LOCK_WR);
    prog.load(LT_DATA, 1'b0, 8'hfc);
    wr(1'b0, 1'b0, 60, 1'b1);
    prog.load(LT_DATA, 1'b0, 8'hff);
    wr(1'b0, 1'b0, 60, 1'b1);
    prog.load(LT_CMD, 1'b0, CMD_FUSE_RD);
    rd(1'b0, 1'b0, 8'ha5);
    rd(1'b1, 1'b1, 8'hf7);
    rd(1'b0, 1'b1, 8'hfd);
    rd(1'b1, 1'b0, 8'hfc);
    $display("fuse and lock test done");
  endtask : t_fuses
  task automatic t_flash();
    prog.load(LT_CMD, 1'b0, CMD_FLASH_WR);
    prog.load(LT_ADDR, 1'b0, 8'h85);
    prog.load(LT_DATA, 1'b0, 8'h34);
    prog.load(LT_DATA, 1'b1, 8'h12);
    prog.latch();
    prog.load(LT_ADDR, 1'b0, 8'h86);
    prog.load(LT_DATA, 1'b0, 8'h78);
    prog.load(LT_DATA, 1'b1, 8'h56);
    prog.latch();
    prog.load(LT_ADDR, 1'b1, 8'h01);
    wr(1'b0, 1'b0, 400, 1'b1);
    wr(1'b1, 1'b0, 12, 1'b0);
    prog.load(LT_CMD, 1'b0, CMD_NOP);
    wr(1'b0, 1'b0, 12, 1'b0);
    prog.load(LT_CMD, 1'b0, CMD_FLASH_RD);
    rd(1'b0, 1'b0, 8'h78);
    rd(1'b1, 1'b0, 8'h56);
    prog.load(LT_ADDR, 1'b0, 8'h85);
    rd(1'b0, 1'b0, 8'h34);
    rd(1'b1, 1'b0, 8'h12);
    $display("flash test done");
  endtask : t_flash
  task automatic t_eeprom();
    prog.load(LT_CMD, 1'b0, CMD_EE_WR);
    prog.load(LT_ADDR, 1'b1, 8'h00);
    prog.load(LT_ADDR, 1'b0, 8'h12);
    prog.load(LT_DATA, 1'b0, 8'hc3);
    prog.latch();
    prog.load(LT_ADDR, 1'b0, 8'h13);
    prog.load(LT_DATA, 1'b0, 8'h3e);
    prog.latch();
    wr(1'b0, 1'b0, 100, 1'b1);
    prog.load(LT_CMD, 1'b0, CMD_EE_RD);
    rd(1'b0, 1'b0, 8'h3e);
    rd(1'b1, 1'b0, 8'hff);
    prog.load(LT_ADDR, 1'b0, 8'h12);
    rd(1'b0, 1'b0, 8'hc3);
    $display("eeprom test done");
  endtask : t_eeprom
  task automatic t_sig();
    logic [7:0] sig [4];
    int         i;
    // Table values are arbitrary identity bytes
    sig = '{8'h5a, 8'h3c, 8'h01, 8'hff};
    prog.load(LT_CMD, 1'b0, CMD_SIG_RD);
    for (i = 0; i < 4; i++) begin
      prog.load(LT_ADDR, 1'b0, 8'(i));
      rd(1'b0, 1'b0, sig[i]);
      rd(1'b1, 1'b0, 8'h80 + 8'(i));
    end
    $display("signature test done");
  endtask : t_sig
  task automatic t_erase();
    prog.load(LT_CMD, 1'b0, CMD_ERASE);
    wr(1'b0, 1'b0, 40000, 1'b1);
    prog.load(LT_CMD, 1'b0, CMD_FLASH_RD);
    prog.load(LT_ADDR, 1'b1, 8'h01);
    prog.load(LT_ADDR, 1'b0, 8'h86);
    rd(1'b0, 1'b0, 8'hff);
    rd(1'b1, 1'b0, 8'hff);
    prog.load(LT_CMD, 1'b0, CMD_EE_RD);
    prog.load(LT_ADDR, 1'b1, 8'h00);
    prog.load(LT_ADDR, 1'b0, 8'h12);
    rd(1'b0, 1'b0, 8'hc3);
    prog.load(LT_CMD, 1'b0, CMD_FUSE_RD);
    rd(1'b1, 1'b0, 8'hff);
    rd(1'b0, 1'b0, 8'ha5);
    rd(1'b1, 1'b1, 8'hf7);
    // Keep-EEPROM fuse back off, so the next erase clears EEPROM
    prog.load(LT_CMD, 1'b0, CMD_FUSE_WR);
    prog.load(LT_DATA, 1'b0, 8'hff);
    wr(1'b1, 1'b0, 60, 1'b1);
    prog.load(LT_CMD, 1'b0, CMD_ERASE);
    wr(1'b0, 1'b0, 40000, 1'b1);
    prog.load(LT_CMD, 1'b0, CMD_EE_RD);
    rd(1'b0, 1'b0, 8'hff);
    $display("erase test done");
  endtask : t_erase
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    bad_count = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_fuses();
    t_flash();
    t_eeprom();
    t_sig();
    t_erase();
    results();
  end
endmodule : tb_ppp_port

`default_nettype wire
